// [rtl/sbtc_top.sv]
// sixteen-bit timer/counter core with prescaler, sync and buffered access
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - run bit 0 gates counting, holds count
// - bit 7 picks buffered or byte access
// - bits 5-4 divide input by 1/2/4/8
// - bit 3 enables the crystal oscillator
// - bit 2 bypasses external input sync
// - bit 1 picks external pin or Fosc/4
// - bit 6 reads zero, ignores writes
// - one count per instruction or rising edge
// - oscillator on forces both pins input
// - count wraps FFFF to 0, sets flag
// - flag raises irq only when enabled
// - special trigger clears count, starts conversion
// - trigger clear never sets overflow flag
// - trigger clear sure only in sync modes
// - software write beats coincident trigger clear
// - buffered low read copies live high to buffer
// - buffered low write loads high together
// - buffered mode hides live high byte
// - only low write clears prescaler count
// - oscillator keeps running during sleep
module sbtc_top
  import sbtc_pkg::*;
(
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST_N,
  // axi4-lite register port
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  // count inputs from pins
  input  wire logic              I_EXT_COUNT_PIN,
  input  wire logic              I_OSC_CLK,
  // core-side context
  input  wire logic              I_SLEEP,
  input  wire logic [3:0]        I_CMP_MODE,
  input  wire logic              I_CMP_EVENT,
  input  wire logic              I_ADC_ENABLED,
  input  wire logic [1:0]        I_PIN_DIR,
  // outputs
  output logic                   O_OSC_ENABLE,
  output logic [1:0]             O_OSC_PIN_OE,
  output logic                   O_OVF_IRQ,
  output logic                   O_ADC_START,
  output logic [15:0]            O_COUNT
);

  sbtc_regbus_if bus ();

  sbtc_axil_slave sbtc_axil_slave_inst (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RST_N),
    .i_awaddr  (I_AWADDR),
    .i_awvalid (I_AWVALID),
    .o_awready (O_AWREADY),
    .i_wdata   (I_WDATA),
    .i_wstrb   (I_WSTRB),
    .i_wvalid  (I_WVALID),
    .o_wready  (O_WREADY),
    .o_bresp   (O_BRESP),
    .o_bvalid  (O_BVALID),
    .i_bready  (I_BREADY),
    .i_araddr  (I_ARADDR),
    .i_arvalid (I_ARVALID),
    .o_arready (O_ARREADY),
    .o_rdata   (O_RDATA),
    .o_rresp   (O_RRESP),
    .o_rvalid  (O_RVALID),
    .i_rready  (I_RREADY),
    .bus       (bus.bus)
  );

  // divide limit of the prescaler for a given select code
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    logic [2:0] lim;
    lim = 3'h0;
    unique case (sel)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      2'h3: lim = 3'h7;
    endcase
    return lim;
  endfunction : div_limit

  // true for every implemented register address
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_LOW) || (a == ADDR_HIGH) ||
           (a == ADDR_FLAG) || (a == ADDR_IEN) || (a == ADDR_STAT);
  endfunction : is_mapped

  logic [7:0]  ctrl_q;
  logic [15:0] cnt_q;
  logic [7:0]  hbuf_q;
  logic        flag_q;
  logic        ien_q;
  logic [1:0]  phase_q;
  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic        prev_q;
  logic        pend_q;
  logic [2:0]  ps_cnt_q;
  logic        adc_q;

  logic        run;
  logic        src_ext;
  logic        bypass;
  logic        osc_en;
  logic        wide;
  logic [1:0]  ps_sel;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_flag;
  logic        wr_ien;
  logic        rd_low;
  logic        instr_tick;
  logic        ext_lvl;
  logic        ext_rise;
  logic        pend_fire;
  logic        count_in;
  logic        adv;
  logic        trig;
  logic        sw_load;
  logic        ovf_evt;

  // control fields
  assign run     = ctrl_q[BIT_RUN];
  assign src_ext = ctrl_q[BIT_SRC];
  assign bypass  = ctrl_q[BIT_BYPASS];
  assign osc_en  = ctrl_q[BIT_OSC];
  assign wide    = ctrl_q[BIT_WIDE];
  assign ps_sel  = ctrl_q[BIT_PS_LO +: 2];

  // register strobe decode
  assign wr_ctrl = bus.wr_en && (bus.wr_addr == ADDR_CTRL);
  assign wr_low  = bus.wr_en && (bus.wr_addr == ADDR_LOW);
  assign wr_high = bus.wr_en && (bus.wr_addr == ADDR_HIGH);
  assign wr_flag = bus.wr_en && (bus.wr_addr == ADDR_FLAG);
  assign wr_ien  = bus.wr_en && (bus.wr_addr == ADDR_IEN);
  assign rd_low  = bus.rd_en && (bus.rd_addr == ADDR_LOW);
  assign bus.wr_hit = is_mapped(bus.wr_addr);
  assign bus.rd_hit = is_mapped(bus.rd_addr);

  // control register; the unused bit is masked off on write
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= bus.wr_data & CTRL_WMASK;
    end
  end

  // instruction-cycle phase; it keeps counting in sleep, where only the tick is gated
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign instr_tick = (phase_q == INSTR_LAST) && !I_SLEEP;

  // both pin inputs pass two flops before anything looks at them
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {I_OSC_CLK, I_EXT_COUNT_PIN};
      sync2_q <= sync1_q;
    end
  end

  // crystal output replaces the pin as count source while enabled
  assign ext_lvl  = osc_en ? sync2_q[1] : sync2_q[0];
  assign ext_rise = ext_lvl & ~prev_q;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= ext_lvl;
    end
  end

  // synchronised mode aligns each edge to the next instruction boundary;
  // two edges inside one instruction cycle merge into one count
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_q <= 1'b0;
    end else if (!src_ext || bypass || instr_tick) begin
      pend_q <= 1'b0;
    end else if (ext_rise) begin
      pend_q <= 1'b1;
    end
  end
  assign pend_fire = (pend_q | ext_rise) & instr_tick;

  // selected count input; bypass is ignored with the internal source
  assign count_in = src_ext ? (bypass ? ext_rise : pend_fire)
                            : instr_tick;

  // prescaler counts only while running; held, not cleared, when stopped
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ps_cnt_q <= 3'h0;
    end else if (wr_low) begin
      ps_cnt_q <= 3'h0;
    end else if (run && count_in) begin
      if (ps_cnt_q >= div_limit(ps_sel)) begin
        ps_cnt_q <= 3'h0;
      end else begin
        ps_cnt_q <= ps_cnt_q + 3'h1;
      end
    end
  end
  assign adv = run && count_in && (ps_cnt_q >= div_limit(ps_sel));

  // special event trigger from the compare unit
  assign trig = I_CMP_EVENT && (I_CMP_MODE == CMP_MODE_SPECIAL);

  // any software store to the counter itself
  assign sw_load = wr_low || (wr_high && !wide);

  // counter: writes first, then trigger clear, then counting.
  // the clear also acts unsynchronised; there it is merely not promised
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_q <= 16'h0000;
    end else if (wr_low) begin
      cnt_q[7:0] <= bus.wr_data;
      if (wide) begin
        cnt_q[15:8] <= hbuf_q;
      end
    end else if (wr_high && !wide) begin
      cnt_q[15:8] <= bus.wr_data;
    end else if (trig) begin
      cnt_q <= 16'h0000;
    end else if (adv) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // wrap only by counting; loads and trigger clears never count as one
  assign ovf_evt = adv && !sw_load && !trig && (cnt_q == 16'hFFFF);

  // overflow flag: hardware set wins over a software clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag_q <= 1'b0;
    end else if (ovf_evt) begin
      flag_q <= 1'b1;
    end else if (wr_flag) begin
      flag_q <= bus.wr_data[BIT_OVF];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ien_q <= 1'b0;
    end else if (wr_ien) begin
      ien_q <= bus.wr_data[BIT_OVF];
    end
  end

  // high-byte buffer; a buffer write in the same cycle as a low read wins
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hbuf_q <= BYTE_RESET;
    end else if (wr_high && wide) begin
      hbuf_q <= bus.wr_data;
    end else if (rd_low && wide) begin
      hbuf_q <= cnt_q[15:8];
    end
  end

  // read mux; status shows pin level, prescaler and pending edge
  always_comb begin
    bus.rd_data = BYTE_RESET;
    unique case (bus.rd_addr)
      ADDR_CTRL: bus.rd_data = ctrl_q;
      ADDR_LOW:  bus.rd_data = cnt_q[7:0];
      ADDR_HIGH: bus.rd_data = wide ? hbuf_q : cnt_q[15:8];
      ADDR_FLAG: bus.rd_data = {7'h00, flag_q};
      ADDR_IEN:  bus.rd_data = {7'h00, ien_q};
      ADDR_STAT: bus.rd_data = {3'h0, pend_q, ps_cnt_q, ext_lvl};
      default:   bus.rd_data = BYTE_RESET;
    endcase
  end

  // conversion start pulse, registered to keep the output glitch free
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      adc_q <= 1'b0;
    end else begin
      adc_q <= trig && I_ADC_ENABLED;
    end
  end

  // oscillator enable ignores sleep so unsynchronised external counting carries on
  assign O_OSC_ENABLE = osc_en;
  // direction bit high means input; the oscillator overrides both pins
  assign O_OSC_PIN_OE = ~I_PIN_DIR & {2{~osc_en}};
  assign O_OVF_IRQ    = flag_q & ien_q;
  assign O_ADC_START  = adc_q;
  assign O_COUNT      = cnt_q;

endmodule : sbtc_top

// [rtl/sbtc_pkg.sv]
// shared constants for the sixteen-bit timer/counter and its bus slave
package sbtc_pkg;
  // register byte addresses, one aligned word each
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_LOW   = 8'h04;
  localparam logic [7:0] ADDR_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_FLAG  = 8'h0C;
  localparam logic [7:0] ADDR_IEN   = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;
  // counter_control_reg field positions, then the overflow flag bit
  localparam int         BIT_RUN    = 0;
  localparam int         BIT_SRC    = 1;
  localparam int         BIT_BYPASS = 2;
  localparam int         BIT_OSC    = 3;
  localparam int         BIT_PS_LO  = 4;
  localparam int         BIT_WIDE   = 7;
  localparam int         BIT_OVF    = 0;
  // values after reset and write masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // compare_mode_field code for the special event trigger
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;
  // last core cycle of an instruction cycle (core clock / 4)
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : sbtc_pkg

// [rtl/sbtc_regbus_if.sv]
// byte register strobes between the bus slave and the counter core
`timescale 1ns/1ps
interface sbtc_regbus_if;
  import sbtc_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_hit;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              rd_hit;
  modport bus  (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input  wr_hit, rd_hit, rd_data);
  modport core (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output wr_hit, rd_hit, rd_data);
endinterface : sbtc_regbus_if

// [rtl/sbtc_axil_slave.sv]
// axi4-lite slave turning bus transfers into one-cycle register strobes
`timescale 1ns/1ps
module sbtc_axil_slave
  import sbtc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  sbtc_regbus_if.bus             bus
);
  logic [ADDR_W-1:0] aw_q;
  logic              aw_full_q;
  logic [7:0]        w_q;
  logic              w_lane_q;
  logic              w_full_q;
  logic              fire;

  // address and data may arrive in either order; each waits in its holder
  assign o_awready = ~aw_full_q;
  assign o_wready  = ~w_full_q;
  assign fire      = aw_full_q & w_full_q & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  // only byte lane 0 carries register data; a write without it is a no-op
  assign bus.wr_en   = fire & w_lane_q;
  assign bus.wr_addr = aw_q;
  assign bus.wr_data = w_q;
  assign bus.rd_en   = i_arvalid & o_arready;
  assign bus.rd_addr = i_araddr;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_q      <= '0;
      aw_full_q <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_q      <= i_awaddr;
      aw_full_q <= 1'b1;
    end else if (fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_q      <= BYTE_RESET;
      w_lane_q <= 1'b0;
      w_full_q <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_q      <= i_wdata[7:0];
      w_lane_q <= i_wstrb[0];
      w_full_q <= 1'b1;
    end else if (fire) begin
      w_full_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= bus.wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // read data captured in the very cycle the core sees the read strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end else if (bus.rd_en) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {24'h000000, bus.rd_data};
      o_rresp  <= bus.rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule : sbtc_axil_slave

// [tb/sbtc_assertions.sv]
// concurrent checks on the timer/counter top ports
`timescale 1ns/1ps
module sbtc_checker
  import sbtc_pkg::*;
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_N,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic        I_SLEEP,
  input wire logic [3:0]  I_CMP_MODE,
  input wire logic        I_CMP_EVENT,
  input wire logic        I_ADC_ENABLED,
  input wire logic [1:0]  I_PIN_DIR,
  input wire logic        O_OSC_ENABLE,
  input wire logic [1:0]  O_OSC_PIN_OE,
  input wire logic        O_ADC_START,
  input wire logic [15:0] O_COUNT
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  pin_force_a:
    assert property (O_OSC_PIN_OE == (~I_PIN_DIR & {2{~O_OSC_ENABLE}}))
    else $error("osc pin driven while oscillator on");
  trig_clear_a:
    assert property (I_CMP_EVENT && I_CMP_MODE == CMP_MODE_SPECIAL
                     |=> O_COUNT == 16'h0000 || $rose(O_BVALID))
    else $error("trigger did not clear count");
  adc_cause_a:
    assert property (O_ADC_START
                     |-> $past(I_CMP_EVENT && I_ADC_ENABLED && I_CMP_MODE == CMP_MODE_SPECIAL))
    else $error("conversion start without trigger");
  count_step_a:
    assert property (O_COUNT != $past(O_COUNT)
                     |-> O_COUNT == $past(O_COUNT) + 16'h0001 || $rose(O_BVALID)
                         || $past(I_CMP_EVENT))
    else $error("count jumped by more than one");
  sleep_osc_a:
    assert property (I_SLEEP && O_OSC_ENABLE |=> O_OSC_ENABLE || $rose(O_BVALID))
    else $error("oscillator dropped in sleep");
  rdata_pad_a:
    assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  ar_ready_a:
    assert property (O_ARREADY == !O_RVALID)
    else $error("read address ready wrong");
  b_once_a:
    assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  r_once_a:
    assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read response repeated");
endmodule : sbtc_checker

// [tb/tb_sbtc_top.sv]
// self-checking bench for the timer/counter over its register bus
`timescale 1ns/1ps
module tb_sbtc_top;
  import sbtc_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic        ext_pin = 1'h0, sleep = 1'h0, cmp_event = 1'h0, adc_en = 1'h0;
  logic        osc_clk = 1'h0, use_osc = 1'h0;
  logic [3:0]  cmp_mode = 4'h0;
  logic [1:0]  pin_dir = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, osc_en, irq, adc_start;
  logic [1:0]  bresp, rresp, pin_oe, resp;
  logic [31:0] rdata, rd;
  logic [15:0] count, hold;
  logic        adc_seen = 1'h0;
  int          error_cnt = 0, tests_run = 0, cyc = 0, n;

  // core clock, 4 ns period
  always #2 clk = ~clk;

  sbtc_top sbtc_top_inst (
    .I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_EXT_COUNT_PIN(ext_pin), .I_OSC_CLK(osc_clk), .I_SLEEP(sleep),
    .I_CMP_MODE(cmp_mode), .I_CMP_EVENT(cmp_event), .I_ADC_ENABLED(adc_en),
    .I_PIN_DIR(pin_dir), .O_OSC_ENABLE(osc_en), .O_OSC_PIN_OE(pin_oe),
    .O_OVF_IRQ(irq), .O_ADC_START(adc_start), .O_COUNT(count));

  task automatic print_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rdx(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rdx

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
    rdx(a);
    chk(rd, {24'h000000, e}, what);
  endtask : rchk

  // high first, so buffered mode lands all sixteen bits at the low write
  task automatic set_count(input logic [15:0] v);
    wr(ADDR_HIGH, v[15:8]);
    wr(ADDR_LOW, v[7:0]);
  endtask : set_count

  // first change only aligns; the second interval is the true period
  task automatic gap(output int c);
    repeat (2) begin
      hold = count;
      c = 0;
      while (count === hold && c < 200) begin
        @(posedge clk);
        c++;
      end
    end
  endtask : gap

  task automatic pulse(input int k, input int w);
    repeat (k) begin
      @(posedge clk);
      if (use_osc) osc_clk <= 1'h1;
      else ext_pin <= 1'h1;
      repeat (w) @(posedge clk);
      if (use_osc) osc_clk <= 1'h0;
      else ext_pin <= 1'h0;
      repeat (w) @(posedge clk);
    end
    repeat (12) @(posedge clk);
  endtask : pulse

  task automatic trig;
    @(posedge clk);
    cmp_event <= 1'h1;
    @(posedge clk);
    cmp_event <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : trig

  // hang guard and conversion-start catcher
  always @(posedge clk) begin
    if (adc_start) adc_seen <= 1'h1;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rchk(ADDR_CTRL, 8'h00, "ctrl reset");
    rchk(ADDR_FLAG, 8'h00, "flag reset");
    chk({16'h0000, count}, 32'h0, "count reset");
    wr(ADDR_CTRL, 8'hFF);
    rchk(ADDR_CTRL, 8'hBF, "bit6 stays zero");
    chk({31'h0, osc_en}, 32'h1, "osc on");
    chk({30'h0, pin_oe}, 32'h0, "pins forced in");
    pin_dir <= 2'h1;
    wr(ADDR_CTRL, 8'h00);
    chk({30'h0, pin_oe}, 32'h2, "pins follow dir");
    rdx(8'h20);
    chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped read");
    wr(8'h03, 8'h55);
    chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped write");
    // timer mode, every divide setting
    for (int ps = 0; ps < 4; ps++) begin
      wr(ADDR_CTRL, 8'(ps << 4) | 8'h01);
      gap(n);
      chk(32'(n), 32'(4 << ps), "divide ratio");
    end
    wr(ADDR_CTRL, 8'h00);
    hold = count;
    repeat (40) @(posedge clk);
    chk({16'h0000, count}, {16'h0000, hold}, "stop holds");
    wr(ADDR_CTRL, 8'h09);
    sleep <= 1'h1;
    repeat (2) @(posedge clk);
    hold = count;
    repeat (40) @(posedge clk);
    chk({16'h0000, count}, {16'h0000, hold}, "sleep halts ticks");
    chk({31'h0, osc_en}, 32'h1, "osc kept in sleep");
    sleep <= 1'h0;
    // wrap, flag and interrupt mask
    wr(ADDR_CTRL, 8'h00);
    set_count(16'hFFFD);
    wr(ADDR_CTRL, 8'h01);
    repeat (30) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_FLAG, 8'h01, "wrap sets flag");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(ADDR_IEN, 8'h01);
    chk({31'h0, irq}, 32'h1, "enabled irq");
    wr(ADDR_FLAG, 8'h00);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    // compare trigger, wrong mode then special mode
    set_count(16'h1234);
    adc_en <= 1'h1;
    cmp_mode <= 4'h5;
    trig();
    chk({16'h0000, count}, 32'h1234, "other mode keeps");
    chk({31'h0, adc_seen}, 32'h0, "no start");
    cmp_mode <= CMP_MODE_SPECIAL;
    trig();
    chk({16'h0000, count}, 32'h0, "trigger clears");
    chk({31'h0, adc_seen}, 32'h1, "start pulsed");
    rchk(ADDR_FLAG, 8'h00, "no flag on clear");
    // buffered sixteen-bit access, then live high byte in byte mode
    wr(ADDR_CTRL, 8'h80);
    set_count(16'h5A3C);
    chk({16'h0000, count}, 32'h5A3C, "wide write");
    wr(ADDR_HIGH, 8'h77);
    chk({16'h0000, count}, 32'h5A3C, "high write buffered");
    rchk(ADDR_HIGH, 8'h77, "buffer readback");
    rchk(ADDR_LOW, 8'h3C, "low read");
    rchk(ADDR_HIGH, 8'h5A, "high copied");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_HIGH, 8'hAB);
    chk({24'h000000, count[15:8]}, 32'hAB, "live high");
    rchk(ADDR_HIGH, 8'hAB, "live high read");
    // external edges: unsynced, synced, divided
    wr(ADDR_CTRL, 8'h06);
    set_count(16'h0000);
    wr(ADDR_CTRL, 8'h07);
    pulse(5, 3);
    chk({16'h0000, count}, 32'h5, "unsynced edges");
    wr(ADDR_CTRL, 8'h02);
    set_count(16'h0000);
    wr(ADDR_CTRL, 8'h03);
    pulse(5, 6);
    chk({16'h0000, count}, 32'h5, "synced edges");
    wr(ADDR_CTRL, 8'hB7);
    set_count(16'h0000);
    pulse(4, 3);
    rchk(ADDR_STAT, 8'h08, "prescaler at four");
    wr(ADDR_HIGH, 8'h00);
    pulse(4, 3);
    chk({16'h0000, count}, 32'h1, "prescaler kept");
    // crystal edges count, even in sleep; the pin is then ignored
    wr(ADDR_CTRL, 8'h0E);
    set_count(16'h0000);
    wr(ADDR_CTRL, 8'h0F);
    use_osc = 1'h1;
    sleep <= 1'h1;
    pulse(3, 3);
    chk({16'h0000, count}, 32'h3, "osc edges in sleep");
    use_osc = 1'h0;
    pulse(2, 3);
    sleep <= 1'h0;
    chk({16'h0000, count}, 32'h3, "pin ignored with osc");
    print_verdict();
  end
endmodule : tb_sbtc_top

bind sbtc_top sbtc_checker sbtc_checker_inst (
  .I_CORE_CLK, .I_RST_N, .O_BVALID, .I_BREADY, .O_ARREADY, .O_RDATA, .O_RVALID,
  .I_RREADY, .I_SLEEP, .I_CMP_MODE, .I_CMP_EVENT, .I_ADC_ENABLED, .I_PIN_DIR,
  .O_OSC_ENABLE, .O_OSC_PIN_OE, .O_ADC_START, .O_COUNT);
